/* hdl/dpi_init_dev.sv */
/*
  Device-side power-up and reset initialization of a DDR4 DRAM:
  default mode fields, internal init timer and ODT hold-off.
  Assumes the controller drives reset, clock enable and ODT from outside,
  and software on the same clock reaches the mode fields over a plain port.
*/
// Our own choices: strobed register access and the register addresses.
// How it works
// - After reset, gear-down, per-device addressing and max power saving default off.
// - After reset, CS latency, parity latency and both repair modes default zero.
// - Device initializes internal state after reset release without the external clock.
// - Termination stays high impedance in reset and until clock enable is high after the internal init wait ends.
`default_nettype none
`include "dpi_params.svh"

module dpi_init_dev
  import dpi_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `DPI_INIT_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link pins from the controller
  input wire logic dram_reset_n,
  input wire logic cke,
  input wire logic odt,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Status
  output logic init_done,
  output logic odt_enable
);

  // Elaboration-time guard: a zero count would wrap INIT_CYCLES - 1 and stretch the init wait to 2^32 cycles
  if (INIT_CYCLES < 1) begin : g_bad_init_cycles
    $error("INIT_CYCLES must be at least 1");
  end

  // Two-flop synchronisers for the pins
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {odt, cke, dram_reset_n};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire pin_rst_n = pin_s2_q[0];
  wire pin_cke = pin_s2_q[1];
  wire pin_odt = pin_s2_q[2];

  dpi_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  dpi_state_t state_q;
  dpi_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [`DPI_MR_W-1:0] mr3_q;
  logic [`DPI_MR_W-1:0] mr4_q;
  logic [`DPI_MR_W-1:0] mr5_q;

  wire cnt_done = (cnt_q >= INIT_CYCLES - 1);

  // Internal init runs on ref_clk alone; the DRAM clock pins play no part
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      DPI_IN_RESET: begin
        cnt_d = 32'h0;
        if (pin_rst_n) begin
          state_d = DPI_INIT_WAIT;
        end
      end
      DPI_INIT_WAIT: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_done) begin
          state_d = DPI_WAIT_CKE;
        end
      end
      DPI_WAIT_CKE: begin
        if (pin_cke) begin
          state_d = DPI_ACTIVE;
        end
      end
      DPI_ACTIVE: begin
      end
    endcase
    if (!pin_rst_n) begin
      state_d = DPI_IN_RESET;
    end
  end

  wire in_dev_reset = !pin_rst_n;
  wire wr_mr3 = req.wr && (req.addr == `DPI_ADDR_MR3);
  wire wr_mr4 = req.wr && (req.addr == `DPI_ADDR_MR4);
  wire wr_mr5 = req.wr && (req.addr == `DPI_ADDR_MR5);
  wire [31:0] stat_word = {28'h0, pin_odt, pin_cke, state_q};
  wire [31:0] rd_mux =
    (req.addr == `DPI_ADDR_MR3) ? {18'h0, mr3_q} :
    (req.addr == `DPI_ADDR_MR4) ? {18'h0, mr4_q} :
    (req.addr == `DPI_ADDR_MR5) ? {18'h0, mr5_q} :
    (req.addr == `DPI_ADDR_STAT) ? stat_word : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DPI_IN_RESET;
      cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Device reset forces the mode defaults again, so a warm reset behaves like power-up
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr3_q <= `DPI_MR3_RST;
      mr4_q <= `DPI_MR4_RST;
      mr5_q <= `DPI_MR5_RST;
    end else if (in_dev_reset) begin
      mr3_q <= `DPI_MR3_RST;
      mr4_q <= `DPI_MR4_RST;
      mr5_q <= `DPI_MR5_RST;
    end else begin
      if (wr_mr3) begin
        mr3_q <= req.wdata[`DPI_MR_W-1:0];
      end
      if (wr_mr4) begin
        mr4_q <= req.wdata[`DPI_MR_W-1:0];
      end
      if (wr_mr5) begin
        mr5_q <= req.wdata[`DPI_MR_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      init_done <= 1'b0;
      odt_enable <= 1'b0;
    end else begin
      reg_rdata <= req.rd ? rd_mux : 32'h0;
      init_done <= (state_d == DPI_ACTIVE);
      odt_enable <= (state_d == DPI_ACTIVE);
    end
  end

  property p_defaults_in_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    in_dev_reset |=> (!mr3_q[`DPI_MR3_GEARDOWN] && !mr3_q[`DPI_MR3_PDA]
                      && !mr4_q[`DPI_MR4_MPSM]);
  endproperty
  a_defaults_in_reset: assert property (p_defaults_in_reset)
    else $error("mode defaults not restored in reset");

  property p_defaults2_in_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    in_dev_reset |=> (mr4_q[`DPI_MR4_CAL_HI:`DPI_MR4_CAL_LO] == 3'h0
                      && mr5_q[`DPI_MR5_PAR_HI:`DPI_MR5_PAR_LO] == 3'h0
                      && !mr4_q[`DPI_MR4_HPPR] && !mr4_q[`DPI_MR4_SPPR]);
  endproperty
  a_defaults2_in_reset: assert property (p_defaults2_in_reset)
    else $error("latency or repair defaults not restored");

  sequence s_release;
    state_q == DPI_IN_RESET ##1 state_q == DPI_INIT_WAIT;
  endsequence
  sequence s_counting;
    state_q == DPI_INIT_WAIT && pin_rst_n && !cnt_done;
  endsequence

  // Every release restarts the internal wait from zero
  property p_init_start;
    @(posedge ref_clk) disable iff (!rst_n)
    s_release |-> cnt_q == 32'h0;
  endproperty
  a_init_start: assert property (p_init_start)
    else $error("init wait did not start from zero");

  // Clock enable has no say until the internal count is spent
  property p_init_ignores_cke;
    @(posedge ref_clk) disable iff (!rst_n)
    s_counting |=> (state_q == DPI_INIT_WAIT && cnt_q == $past(cnt_q) + 32'h1);
  endproperty
  a_init_ignores_cke: assert property (p_init_ignores_cke)
    else $error("init wait ended early");

  property p_init_count_end;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q == DPI_INIT_WAIT && pin_rst_n && cnt_done) |=> state_q == DPI_WAIT_CKE;
  endproperty
  a_init_count_end: assert property (p_init_count_end)
    else $error("init wait did not end on its count");

  property p_odt_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_q != DPI_ACTIVE) |-> (!odt_enable && !init_done);
  endproperty
  a_odt_off: assert property (p_odt_off)
    else $error("termination enabled before clock enable");

  property p_odt_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    in_dev_reset |=> !odt_enable;
  endproperty
  a_odt_reset: assert property (p_odt_reset)
    else $error("termination enabled during reset");

  property p_odt_after_cke;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(odt_enable) |-> ($past(pin_cke) && $past(state_q) == DPI_WAIT_CKE);
  endproperty
  a_odt_after_cke: assert property (p_odt_after_cke)
    else $error("termination left high impedance without clock enable");

endmodule

`default_nettype wire

/* hdl/dpi_params.svh */
/*
  Constants for the DRAM power-up and initialization device-side block.
  Assumes a 100 MHz ref_clk; times are kept in their own unit and
  converted to cycle counts here.
*/
`ifndef DPI_PARAMS_SVH
`define DPI_PARAMS_SVH

`define DPI_CLK_PERIOD_NS 10
// Internal state initialization time after reset release
`define DPI_INIT_TIME_NS 500000
`define DPI_INIT_CYCLES ((`DPI_INIT_TIME_NS + `DPI_CLK_PERIOD_NS - 1) / `DPI_CLK_PERIOD_NS)

// Register map, word index times four
`define DPI_ADDR_MR3 8'h00
`define DPI_ADDR_MR4 8'h04
`define DPI_ADDR_MR5 8'h08
`define DPI_ADDR_STAT 8'h0c

// Mode register field positions
`define DPI_MR3_GEARDOWN 3
`define DPI_MR3_PDA 4
`define DPI_MR4_MPSM 1
`define DPI_MR4_SPPR 5
`define DPI_MR4_CAL_LO 6
`define DPI_MR4_CAL_HI 8
`define DPI_MR4_HPPR 13
`define DPI_MR5_PAR_LO 0
`define DPI_MR5_PAR_HI 2

// Reset values of the mode registers
`define DPI_MR3_RST 14'h0000
`define DPI_MR4_RST 14'h0000
`define DPI_MR5_RST 14'h0000

`define DPI_MR_W 14

`endif

/* hdl/dpi_pkg.sv */
/*
  Types for the DRAM power-up and initialization block.
  Assumes dpi_params.svh is available on the include path.
*/
`default_nettype none
`include "dpi_params.svh"

package dpi_pkg;
  typedef enum logic [1:0] {
    DPI_IN_RESET,
    DPI_INIT_WAIT,
    DPI_WAIT_CKE,
    DPI_ACTIVE
  } dpi_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dpi_bus_req_t;
endpackage

`default_nettype wire

/* verification/dpi_ctrl_model.sv */
/*
  Controller-side model: drives the reset, clock enable and odt pins.
  Assumes the bench raises hold to ask for a DRAM reset, on ref_clk,
  and quick for a short clock-enable wait that still spans 5 clock periods.
  Command pins are not modelled: they idle at deselect, and no
  no-operation command is ever sent.
*/
`default_nettype none
module dpi_ctrl_model #(
  parameter int WAIT_CYC = 40
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench request
  input wire logic hold,
  input wire logic quick,
  // Pins to the device
  output logic dram_reset_n,
  output logic cke,
  output logic odt
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int wait_cyc;
  // A quick start raises clock enable while the device is still counting
  assign wait_cyc = quick ? WAIT_CYC / 8 : WAIT_CYC;
  // Termination request stays low so nominal termination may be enabled
  assign odt = 1'b0;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n || hold) begin
      // Clock enable drops with reset, so it is low well before release
      dram_reset_n <= 1'b0;
      cke <= 1'b0;
      cnt <= 0;
    end else begin
      dram_reset_n <= 1'b1;
      // Counted wait before clock enable, then held high until the next reset or hold
      if (cnt < wait_cyc) begin
        cnt <= cnt + 1;
      end else begin
        cke <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb_dpi_init_dev.sv */
/*
  Self-checking bench for the device-side init block.
  Assumes the controller model on the pins and a 100 MHz ref_clk.
*/
`default_nettype none
`include "dpi_params.svh"
module tb_dpi_init_dev
  import dpi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold = 1'b1;
  logic quick = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic dram_reset_n, cke, odt, init_done, odt_enable;
  int fails = 0;
  int n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  dpi_ctrl_model #(.WAIT_CYC(40)) dpi_ctrl_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .hold(hold), .quick(quick), .dram_reset_n(dram_reset_n), .cke(cke), .odt(odt));
  // Short init count keeps the run brief
  dpi_init_dev #(.INIT_CYCLES(20)) dpi_init_dev_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .dram_reset_n(dram_reset_n), .cke(cke), .odt(odt), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .init_done(init_done), .odt_enable(odt_enable));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  // Status outputs are looked at mid-cycle, away from the edge that moves them
  task automatic out_chk(input logic exp_done);
    @(negedge ref_clk);
    check(init_done, exp_done);
    check(odt_enable, exp_done);
    @(posedge ref_clk);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 100 && init_done !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
  endtask
  task automatic end_of_test;
    $display("counts: %0d compared, %0d bad", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic defaults;
    rchk(`DPI_ADDR_MR3, 32'h0);
    rchk(`DPI_ADDR_MR4, 32'h0);
    rchk(`DPI_ADDR_MR5, 32'h0);
  endtask
  initial begin
    #100us;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    defaults();
    // Writes while the pin reset is low are dropped
    wr(`DPI_ADDR_MR4, 32'hffff_ffff);
    rchk(`DPI_ADDR_MR4, 32'h0);
    rchk(`DPI_ADDR_STAT, {30'h0, DPI_IN_RESET});
    out_chk(1'b0);
    $display("test done: defaults in reset");
    hold <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rchk(`DPI_ADDR_STAT, {30'h0, DPI_INIT_WAIT});
    out_chk(1'b0);
    repeat (20) @(posedge ref_clk);
    rchk(`DPI_ADDR_STAT, {30'h0, DPI_WAIT_CKE});
    out_chk(1'b0);
    wait_done();
    out_chk(1'b1);
    rchk(`DPI_ADDR_STAT, {29'h0, 1'b1, DPI_ACTIVE});
    $display("test done: init sequence");
    // Mode loads wait out the reset-exit time after clock enable
    repeat (5) @(posedge ref_clk);
    wr(`DPI_ADDR_MR3, 32'hffff_ffff);
    wr(`DPI_ADDR_MR5, 32'h0000_2aaa);
    wr(`DPI_ADDR_MR4, 32'h1234_5678);
    wr(8'h10, 32'hffff_ffff);
    // The later mode load and calibration lie beyond this block; only their time passes
    repeat (2) @(posedge ref_clk);
    rchk(`DPI_ADDR_MR3, 32'h0000_3fff);
    rchk(`DPI_ADDR_MR4, 32'h0000_1678);
    rchk(`DPI_ADDR_MR5, 32'h0000_2aaa);
    rchk(8'h10, 32'h0);
    $display("test done: register access");
    // Warm reset from the pin brings the defaults back
    hold <= 1'b1;
    repeat (5) @(posedge ref_clk);
    out_chk(1'b0);
    defaults();
    $display("test done: warm reset");
    // Clock enable arrives during the internal wait and must be ignored until it ends
    quick <= 1'b1;
    hold <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rchk(`DPI_ADDR_STAT, {29'h0, 1'b1, DPI_INIT_WAIT});
    out_chk(1'b0);
    wait_done();
    out_chk(1'b1);
    rchk(`DPI_ADDR_STAT, {29'h0, 1'b1, DPI_ACTIVE});
    $display("test done: early clock enable");
    end_of_test();
  end
endmodule
`default_nettype wire
